//--- rtl/touch_pkg.sv
package touch_pkg;

  // ****************************************
  // Clock and timer
  // ****************************************
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [11:0] DLY0_US = 12'h001;
  localparam logic [11:0] DLY1_US = 12'h00A;
  localparam logic [11:0] DLY2_US = 12'h014;
  localparam logic [11:0] DLY3_US = 12'h028;

  // ****************************************
  // Result storage
  // ****************************************
  localparam int FIFO_BITS = 1024;
  localparam int ENTRY_W = 16;
  localparam int FIFO_DEPTH = FIFO_BITS / ENTRY_W;
  localparam int RES_W = 12;
  localparam int RES_LSB = 4;
  localparam int MEASURE_KIND_TAG_LSB = 2;
  localparam int EVENT_TAG_LSB = 0;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] ADDR_CFG = 4'h0;
  localparam logic [3:0] ADDR_TIME = 4'h1;
  localparam logic [3:0] ADDR_SETUP = 4'h2;
  localparam logic [3:0] ADDR_SINGLE = 4'h3;
  localparam logic [3:0] ADDR_COMB = 4'h4;
  localparam logic [3:0] ADDR_FIFO = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam logic [3:0] ADDR_WINDOW = 4'h7;
  localparam logic [3:0] ADDR_RESULT = 4'h8;

  localparam int CFG_SELF = 0;
  localparam int CFG_EDGE = 1;
  localparam int CFG_LEVEL = 2;
  localparam int CFG_RCLR = 3;
  localparam int CFG_WIN = 4;
  localparam int CFG_PUSEL = 5;
  localparam int CFG_COMB = 6;
  localparam int TIME_FINE = 0;
  localparam int TIME_FAST = 2;
  localparam int TIME_EDGE = 4;
  localparam int TIME_SCAN = 6;
  localparam int TIME_UNTIMED = 8;
  localparam int CMD_HOLD = 0;
  localparam int CMD_KIND = 1;
  localparam int ST_COUNT = 0;
  localparam int ST_FULL = 7;
  localparam int ST_TOUCH = 8;
  localparam int ST_STATE = 9;

  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] TIME_RST = 16'h0055;
  localparam logic [11:0] WINDOW_RST = 12'h000;

  // ****************************************
  // Codes
  // ****************************************
  localparam logic [1:0] KIND_X = 2'h0;
  localparam logic [1:0] KIND_Y = 2'h1;
  localparam logic [1:0] KIND_ZA = 2'h2;
  localparam logic [1:0] KIND_ZB = 2'h3;
  localparam logic [1:0] EV_INIT = 2'h0;
  localparam logic [1:0] EV_HOLD_SETUP_BIT = 2'h1;
  localparam logic [1:0] EV_REL = 2'h2;

  typedef enum logic [5:0] {
    ST_WATCH = 6'h01,
    ST_FAST_PU = 6'h02,
    ST_FINE_PU = 6'h04,
    ST_SETUP_WAIT = 6'h08,
    ST_CONVERT = 6'h10,
    ST_LOW_POWER = 6'h20
  } scan_state_t;

endpackage

//--- rtl/result_fifo.sv
`timescale 1ns/10ps
module result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 64
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("result_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [CW-1:0] count_r, count_nxt;
  logic push, pop;

  assign in_ready = (count_r != CW'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];
  assign count = count_r;

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    count_nxt = count_r + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end
endmodule

//--- rtl/touch_scan_ctrl.sv
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module touch_scan_ctrl #(
  parameter int FIFO_DEPTH = touch_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic touch_det,
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [11:0] adc_data,
  output logic [1:0] meas_kind,
  output logic xp_drive,
  output logic pullup_en,
  output logic pullup_sel,
  output logic touch_irq_n
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  if (FIFO_DEPTH * touch_pkg::ENTRY_W != touch_pkg::FIFO_BITS) begin : g_bad_depth
    $error("touch_scan_ctrl store must hold exactly its documented bit count");
  end

  // ****************************************
  // Pin sync and timer tick
  // ****************************************
  logic touch_meta_r, touch_s_r, touch_prev_r;
  logic [6:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_r, tick_nxt;

  always_ff @(posedge clk) begin
    if (rst) begin
      touch_meta_r <= 1'b0;
      touch_s_r <= 1'b0;
      touch_prev_r <= 1'b0;
    end else begin
      touch_meta_r <= touch_det;
      touch_s_r <= touch_meta_r;
      touch_prev_r <= touch_s_r;
    end
  end

  always_comb begin
    tick_nxt = (tick_cnt_r == 7'(touch_pkg::TICK_CYC - 1));
    tick_cnt_nxt = tick_nxt ? 7'h00 : tick_cnt_r + 7'h01;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_r <= 7'h00;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  function automatic logic [11:0] dly_of(input logic [1:0] sel);
    logic [11:0] us;
    us = touch_pkg::DLY0_US;
    unique case (sel)
      2'h0: us = touch_pkg::DLY0_US;
      2'h1: us = touch_pkg::DLY1_US;
      2'h2: us = touch_pkg::DLY2_US;
      2'h3: us = touch_pkg::DLY3_US;
    endcase
    // One extra tick since the tick phase is arbitrary at load
    return us + 12'h001;
  endfunction

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [15:0] cfg_r, cfg_nxt, time_r, time_nxt;
  logic [11:0] window_r, window_nxt;
  logic self_mode, edge_mode, level_mode, rclr_mode, win_mode;

  assign self_mode = cfg_r[touch_pkg::CFG_SELF];
  assign edge_mode = cfg_r[touch_pkg::CFG_EDGE];
  assign level_mode = cfg_r[touch_pkg::CFG_LEVEL];
  assign rclr_mode = cfg_r[touch_pkg::CFG_RCLR] && self_mode;
  assign win_mode = cfg_r[touch_pkg::CFG_WIN] && self_mode;

  always_comb begin
    cfg_nxt = cfg_r;
    time_nxt = time_r;
    window_nxt = window_r;
    if (wr && addr == touch_pkg::ADDR_CFG) begin
      cfg_nxt = wdata;
    end
    if (wr && addr == touch_pkg::ADDR_TIME) begin
      time_nxt = wdata;
    end
    if (wr && addr == touch_pkg::ADDR_WINDOW) begin
      window_nxt = wdata[11:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r <= touch_pkg::CFG_RST;
      time_r <= touch_pkg::TIME_RST;
      window_r <= touch_pkg::WINDOW_RST;
    end else begin
      cfg_r <= cfg_nxt;
      time_r <= time_nxt;
      window_r <= window_nxt;
    end
  end

  // ****************************************
  // Scan sequencer
  // ****************************************
  touch_pkg::scan_state_t state_r, state_nxt;
  logic [11:0] dly_r, dly_nxt;
  logic [1:0] idx_r, idx_nxt, last_r, last_nxt, kind_r, kind_nxt;
  logic hold_r, hold_nxt, auto_r, auto_nxt, wait_r, wait_nxt, first_r, first_nxt;
  logic [11:0] last_x_r, last_x_nxt, last_y_r, last_y_nxt, result_r, result_nxt;
  logic seen_r, seen_nxt, start_nxt;
  logic push, fifo_ready, fifo_valid, pop;
  logic [15:0] push_data, fifo_data;
  logic [CW-1:0] fifo_count;
  logic [1:0] cur_kind, ev_tag;
  logic [11:0] diff;
  logic near;
  logic cmd_ok, setup_cmd, single_cmd, comb_cmd, dly_done;

  assign cur_kind = kind_r + idx_r;
  assign dly_done = (dly_r == 12'h000);
  assign cmd_ok = !self_mode && (state_r == touch_pkg::ST_WATCH
    || state_r == touch_pkg::ST_LOW_POWER || state_r == touch_pkg::ST_SETUP_WAIT);
  assign setup_cmd = wr && addr == touch_pkg::ADDR_SETUP && cmd_ok;
  assign comb_cmd = wr && addr == touch_pkg::ADDR_COMB && cmd_ok;
  assign single_cmd = wr && addr == touch_pkg::ADDR_SINGLE && !self_mode
    && state_r == touch_pkg::ST_SETUP_WAIT;

  always_comb begin
    state_nxt = state_r;
    dly_nxt = (tick_r && !dly_done) ? dly_r - 12'h001 : dly_r;
    idx_nxt = idx_r;
    last_nxt = last_r;
    kind_nxt = kind_r;
    hold_nxt = hold_r;
    auto_nxt = auto_r;
    wait_nxt = wait_r;
    first_nxt = first_r;
    last_x_nxt = last_x_r;
    last_y_nxt = last_y_r;
    seen_nxt = seen_r;
    result_nxt = result_r;
    start_nxt = 1'b0;
    push = 1'b0;
    diff = 12'h000;
    near = 1'b0;
    ev_tag = !touch_s_r ? touch_pkg::EV_REL
      : (first_r ? touch_pkg::EV_INIT : touch_pkg::EV_HOLD_SETUP_BIT);
    push_data = {adc_data, cur_kind, ev_tag};
    unique case (state_r)
      touch_pkg::ST_WATCH: begin
        // Untimed; leaves only on a touch in self mode or a host command
        first_nxt = 1'b1;
        if (self_mode && touch_s_r) begin
          kind_nxt = touch_pkg::KIND_X;
          last_nxt = 2'h1 + cfg_r[touch_pkg::CFG_COMB +: 2];
          auto_nxt = 1'b1;
          hold_nxt = 1'b0;
          state_nxt = touch_pkg::ST_FAST_PU;
          dly_nxt = dly_of(time_r[touch_pkg::TIME_FAST +: 2]);
        end
      end
      touch_pkg::ST_FAST_PU: begin
        if (dly_done) begin
          state_nxt = touch_pkg::ST_FINE_PU;
          dly_nxt = dly_of(time_r[touch_pkg::TIME_FINE +: 2]);
        end
      end
      touch_pkg::ST_FINE_PU: begin
        if (!self_mode && time_r[touch_pkg::TIME_UNTIMED] && !auto_r) begin
          state_nxt = touch_pkg::ST_SETUP_WAIT;
        end else if (dly_done) begin
          state_nxt = auto_r ? touch_pkg::ST_CONVERT : touch_pkg::ST_SETUP_WAIT;
          idx_nxt = 2'h0;
          wait_nxt = 1'b0;
        end
      end
      touch_pkg::ST_SETUP_WAIT: begin
        if (single_cmd) begin
          hold_nxt = wdata[touch_pkg::CMD_HOLD];
          kind_nxt = wdata[touch_pkg::CMD_KIND +: 2];
          last_nxt = 2'h0;
          idx_nxt = 2'h0;
          wait_nxt = 1'b0;
          state_nxt = touch_pkg::ST_CONVERT;
        end
      end
      touch_pkg::ST_CONVERT: begin
        if (!wait_r && (!self_mode || fifo_ready)) begin
          // One conversion in flight, and in self mode a free slot before it starts
          start_nxt = 1'b1;
          wait_nxt = 1'b1;
        end else if (wait_r && adc_done) begin
          wait_nxt = 1'b0;
          first_nxt = !touch_s_r;
          result_nxt = adc_data;
          if (cur_kind == touch_pkg::KIND_X) begin
            diff = adc_data > last_x_r ? adc_data - last_x_r : last_x_r - adc_data;
          end else begin
            diff = adc_data > last_y_r ? adc_data - last_y_r : last_y_r - adc_data;
          end
          near = win_mode && seen_r && diff <= window_r
            && (cur_kind == touch_pkg::KIND_X || cur_kind == touch_pkg::KIND_Y);
          push = self_mode && !near;
          if (push && cur_kind == touch_pkg::KIND_X) begin
            last_x_nxt = adc_data;
          end
          if (push && cur_kind == touch_pkg::KIND_Y) begin
            last_y_nxt = adc_data;
            seen_nxt = 1'b1;
          end
          if (idx_r != last_r) begin
            idx_nxt = idx_r + 2'h1;
          end else if (!self_mode && hold_r) begin
            state_nxt = touch_pkg::ST_SETUP_WAIT;
          end else if (touch_s_r && (self_mode || edge_mode)) begin
            state_nxt = touch_pkg::ST_LOW_POWER;
            dly_nxt = dly_of(time_r[touch_pkg::TIME_SCAN +: 2]);
          end else begin
            state_nxt = touch_pkg::ST_WATCH;
          end
        end
      end
      touch_pkg::ST_LOW_POWER: begin
        if (self_mode && dly_done) begin
          state_nxt = touch_pkg::ST_FAST_PU;
          dly_nxt = dly_of(time_r[touch_pkg::TIME_FAST +: 2]);
        end
      end
      default: begin
        state_nxt = touch_pkg::ST_WATCH;
      end
    endcase
    if (setup_cmd || comb_cmd) begin
      hold_nxt = setup_cmd && wdata[touch_pkg::CMD_HOLD];
      auto_nxt = comb_cmd;
      kind_nxt = setup_cmd ? wdata[touch_pkg::CMD_KIND +: 2] : touch_pkg::KIND_X;
      last_nxt = comb_cmd ? 2'h1 + wdata[1:0] : 2'h0;
      state_nxt = touch_pkg::ST_FAST_PU;
      dly_nxt = dly_of(time_r[touch_pkg::TIME_FAST +: 2]);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= touch_pkg::ST_WATCH;
      dly_r <= 12'h000;
      idx_r <= 2'h0;
      last_r <= 2'h0;
      kind_r <= touch_pkg::KIND_X;
      hold_r <= 1'b0;
      auto_r <= 1'b0;
      wait_r <= 1'b0;
      first_r <= 1'b1;
      last_x_r <= 12'h000;
      last_y_r <= 12'h000;
      seen_r <= 1'b0;
      result_r <= 12'h000;
      adc_start <= 1'b0;
      meas_kind <= touch_pkg::KIND_X;
      xp_drive <= 1'b0;
      pullup_en <= 1'b1;
      pullup_sel <= 1'b0;
    end else begin
      state_r <= state_nxt;
      dly_r <= dly_nxt;
      idx_r <= idx_nxt;
      last_r <= last_nxt;
      kind_r <= kind_nxt;
      hold_r <= hold_nxt;
      auto_r <= auto_nxt;
      wait_r <= wait_nxt;
      first_r <= first_nxt;
      last_x_r <= last_x_nxt;
      last_y_r <= last_y_nxt;
      seen_r <= seen_nxt;
      result_r <= result_nxt;
      adc_start <= start_nxt;
      meas_kind <= kind_nxt + idx_nxt;
      xp_drive <= (state_nxt == touch_pkg::ST_FAST_PU);
      // Pullup off while converting and in low power to save current
      pullup_en <= (state_nxt != touch_pkg::ST_CONVERT)
        && (state_nxt != touch_pkg::ST_LOW_POWER);
      pullup_sel <= cfg_r[touch_pkg::CFG_PUSEL];
    end
  end

  // ****************************************
  // Result store
  // ****************************************
  assign pop = rd && addr == touch_pkg::ADDR_FIFO;

  result_fifo #(
    .WIDTH(touch_pkg::ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(push_data),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data),
    .count(fifo_count)
  );

  // ****************************************
  // Interrupt and read port
  // ****************************************
  logic [11:0] pulse_r, pulse_nxt;
  logic pend_r, pend_nxt, irq_nxt;
  logic [15:0] rdata_nxt;

  always_comb begin
    pulse_nxt = (tick_r && pulse_r != 12'h000) ? pulse_r - 12'h001 : pulse_r;
    if (!edge_mode || self_mode) begin
      // No pulse left over from another mode may show after a mode change
      pulse_nxt = 12'h000;
    end else if (touch_s_r && !touch_prev_r) begin
      pulse_nxt = dly_of(time_r[touch_pkg::TIME_EDGE +: 2]);
    end
    // New data wins over a read in the same cycle
    pend_nxt = push || (pend_r && !pop);
    if (self_mode) begin
      irq_nxt = rclr_mode ? pend_nxt : (fifo_count != '0 || push);
    end else if (level_mode) begin
      irq_nxt = touch_s_r;
    end else if (edge_mode) begin
      irq_nxt = pulse_nxt != 12'h000;
    end else begin
      irq_nxt = 1'b0;
    end
    rdata_nxt = 16'h0000;
    if (rd) begin
      unique case (addr)
        touch_pkg::ADDR_CFG: rdata_nxt = cfg_r;
        touch_pkg::ADDR_TIME: rdata_nxt = time_r;
        touch_pkg::ADDR_WINDOW: rdata_nxt = {4'h0, window_r};
        touch_pkg::ADDR_FIFO: rdata_nxt = fifo_valid ? fifo_data : 16'h0000;
        touch_pkg::ADDR_RESULT: rdata_nxt = {result_r, meas_kind, 2'h0};
        touch_pkg::ADDR_STATUS: begin
          rdata_nxt[touch_pkg::ST_COUNT +: CW] = fifo_count;
          rdata_nxt[touch_pkg::ST_FULL] = !fifo_ready;
          rdata_nxt[touch_pkg::ST_TOUCH] = touch_s_r;
          rdata_nxt[touch_pkg::ST_STATE +: 6] = state_r;
        end
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_r <= 12'h000;
      pend_r <= 1'b0;
      touch_irq_n <= 1'b1;
      rdata <= 16'h0000;
    end else begin
      pulse_r <= pulse_nxt;
      pend_r <= pend_nxt;
      touch_irq_n <= !irq_nxt;
      rdata <= rdata_nxt;
    end
  end
endmodule

//--- sim/touch_scan_ctrl_properties.sv
`timescale 1ns/10ps
module touch_scan_ctrl_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic touch_det,
  input wire logic adc_start,
  input wire logic adc_done,
  input wire logic xp_drive,
  input wire logic pullup_en,
  input wire logic pullup_sel,
  input wire logic touch_irq_n
);
  // ****************************************
  // Shadow of the mode register
  // ****************************************
  logic [15:0] cfg_r;
  logic [15:0] cfg_nxt;
  logic lvl;
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr && addr == touch_pkg::ADDR_CFG) begin
      cfg_nxt = wdata;
    end
  end
  always_ff @(posedge clk) begin
    cfg_r <= rst ? 16'h0000 : cfg_nxt;
  end
  assign lvl = cfg_r[2] && !cfg_r[1] && !cfg_r[0];

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_start_pulse: assert property (adc_start |=> !adc_start)
    else $error("conversion start longer than one cycle");
  chk_done_gap: assert property (adc_done |=> !adc_start)
    else $error("next conversion started too early");
  chk_fast_beside: assert property (xp_drive |-> pullup_en)
    else $error("drive switch closed without pullup");
  chk_fine_follows: assert property ($fell(xp_drive) |-> pullup_en && !adc_start)
    else $error("fine pullup phase skipped");
  chk_pullup_select: assert property (wr && addr == touch_pkg::ADDR_CFG |-> ##2 pullup_sel == $past(wdata[5], 2))
    else $error("pullup select does not follow mode");
  chk_level_low: assert property ((lvl && touch_det) [*4] |-> !touch_irq_n)
    else $error("level interrupt not low while touched");
  chk_level_high: assert property ((lvl && !touch_det) [*4] |-> touch_irq_n)
    else $error("level interrupt low without touch");
  chk_self_new_data: assert property (cfg_r[0] && !cfg_r[4] && adc_done |-> ##[1:3] !touch_irq_n)
    else $error("new stored data not flagged");
  chk_host_quiet: assert property ($past(cfg_r[2:0]) == 3'h0 && cfg_r[2:0] == 3'h0 |-> touch_irq_n)
    else $error("interrupt in host mode without irq mode");
endmodule

bind touch_scan_ctrl touch_scan_ctrl_properties chk_u (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .touch_det(touch_det),
  .adc_start(adc_start), .adc_done(adc_done), .xp_drive(xp_drive), .pullup_en(pullup_en),
  .pullup_sel(pullup_sel), .touch_irq_n(touch_irq_n)
);

//--- sim/adc_model.sv
`timescale 1ns/10ps
module adc_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic adc_start,
  input wire logic [3:0] lat,
  input wire logic [11:0] sample,
  output logic adc_done = 1'b0,
  output logic [11:0] adc_data = 12'h5A5
);
  int cnt = 0;
  // Data toggles outside the done cycle so a late capture shows up
  always @(posedge clk) begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (rst) begin
      cnt <= 0;
    end else if (adc_start) begin
      cnt <= int'(lat);
    end else if (cnt == 1) begin
      adc_done <= 1'b1;
      adc_data <= sample;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

//--- sim/touch_scan_irq_logic_tb.sv
`timescale 1ns/10ps
module touch_scan_irq_logic_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic touch_det = 1'b0;
  logic [11:0] sample = 12'h3A1;
  logic [15:0] rdata;
  logic adc_start, adc_done, xp_drive, pullup_en, pullup_sel, touch_irq_n;
  logic [11:0] adc_data;
  logic [1:0] meas_kind;
  int bad_count = 0;
  int n_checks = 0;

  touch_scan_ctrl dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .touch_det(touch_det), .adc_start(adc_start), .adc_done(adc_done),
    .adc_data(adc_data), .meas_kind(meas_kind), .xp_drive(xp_drive), .pullup_en(pullup_en),
    .pullup_sel(pullup_sel), .touch_irq_n(touch_irq_n));
  adc_model adc_u (.clk(clk), .rst(rst), .adc_start(adc_start), .lat(4'h3), .sample(sample),
    .adc_done(adc_done), .adc_data(adc_data));

  initial begin
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Bus and check helpers
  // ****************************************
  task summarize;
    if (bad_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Bounded so a stuck design ends in a failed compare, not a hang
  task automatic wait_hi(ref logic s, input logic v);
    int i = 0;
    do begin
      @(posedge clk);
      #1 i++;
    end while (s !== v && i < 3000);
    chk("wait_level", {15'h0000, v}, {15'h0000, s});
  endtask
  task wait_state(input logic [5:0] s);
    logic [15:0] d;
    for (int i = 0; i < 400; i++) begin
      rd_reg(touch_pkg::ADDR_STATUS, d);
      if (d[14:9] === s) break;
    end
    chk("state", {10'h000, s}, {10'h000, d[14:9]});
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    logic [15:0] d;
    #1 chk("irq_n", 16'h0001, {15'h0000, touch_irq_n});
    chk("xp_drive", 16'h0000, {15'h0000, xp_drive});
    rd_reg(touch_pkg::ADDR_TIME, d);
    chk("time_reg", touch_pkg::TIME_RST, d);
    wr_reg(4'hF, 16'hFFFF);
    rd_reg(4'hF, d);
    chk("unmapped", 16'h0000, d);
    rd_reg(touch_pkg::ADDR_STATUS, d);
    chk("status", 16'h0200, d);
  endtask
  task t_level;
    wr_reg(touch_pkg::ADDR_CFG, 16'h0024);
    @(posedge clk);
    touch_det <= 1'b1;
    repeat (5) @(posedge clk);
    #1 chk("irq_n", 16'h0000, {15'h0000, touch_irq_n});
    chk("pullup_sel", 16'h0001, {15'h0000, pullup_sel});
    @(posedge clk);
    touch_det <= 1'b0;
    repeat (5) @(posedge clk);
    #1 chk("irq_n", 16'h0001, {15'h0000, touch_irq_n});
  endtask
  task t_edge;
    int n;
    n = 0;
    wr_reg(touch_pkg::ADDR_CFG, 16'h0002);
    wr_reg(touch_pkg::ADDR_TIME, 16'h0040);
    #1 chk("irq_idle", 16'h0001, {15'h0000, touch_irq_n});
    @(posedge clk);
    touch_det <= 1'b1;
    repeat (1000) begin
      @(posedge clk);
      #1 if (touch_irq_n === 1'b0) n++;
    end
    chk("irq_n", 16'h0001, {15'h0000, touch_irq_n});
    chk("pulse_ok", 16'h0001, {15'h0000, n > touch_pkg::TICK_CYC && n <= 2 * touch_pkg::TICK_CYC});
  endtask
  task t_host;
    logic [15:0] d;
    wr_reg(touch_pkg::ADDR_CFG, 16'h0000);
    wr_reg(touch_pkg::ADDR_SETUP, 16'h0003);
    wait_hi(xp_drive, 1'b1);
    chk("pullup_fast", 16'h0001, {15'h0000, pullup_en});
    wait_hi(xp_drive, 1'b0);
    chk("pullup_fine", 16'h0001, {15'h0000, pullup_en});
    wait_state(6'h08);
    wr_reg(touch_pkg::ADDR_SINGLE, 16'h0003);
    wait_hi(adc_done, 1'b1);
    rd_reg(touch_pkg::ADDR_RESULT, d);
    chk("result", {sample, touch_pkg::KIND_Y, 2'h0}, d);
    wait_state(6'h08);
    wr_reg(touch_pkg::ADDR_SINGLE, 16'h0002);
    wait_state(6'h01);
    rd_reg(touch_pkg::ADDR_STATUS, d);
    chk("count", 16'h0000, {9'h000, d[6:0]});
    // Untimed fine phase: the host paces the wait itself
    wr_reg(touch_pkg::ADDR_TIME, 16'h0140);
    wr_reg(touch_pkg::ADDR_SETUP, 16'h0000);
    wait_hi(xp_drive, 1'b1);
    wait_hi(xp_drive, 1'b0);
    rd_reg(touch_pkg::ADDR_STATUS, d);
    chk("untimed", 16'h0008, {10'h000, d[14:9]});
  endtask
  task t_comb;
    wr_reg(touch_pkg::ADDR_COMB, 16'h0002);
    for (int k = 0; k < 4; k++) begin
      wait_hi(adc_start, 1'b1);
      chk("kind", 16'(k), {14'h0000, meas_kind});
    end
    wait_state(6'h01);
  endtask
  task t_self;
    logic [15:0] d;
    wr_reg(touch_pkg::ADDR_CFG, 16'h0009);
    wait_hi(adc_done, 1'b1);
    wait_hi(adc_done, 1'b1);
    repeat (3) @(posedge clk);
    #1 chk("irq_n", 16'h0000, {15'h0000, touch_irq_n});
    rd_reg(touch_pkg::ADDR_STATUS, d);
    chk("count", 16'h0002, {9'h000, d[6:0]});
    chk("state", 16'h0020, {10'h000, d[14:9]});
    chk("pullup_lp", 16'h0000, {15'h0000, pullup_en});
    rd_reg(touch_pkg::ADDR_FIFO, d);
    chk("entry_x", {sample, touch_pkg::KIND_X, touch_pkg::EV_INIT}, d);
    repeat (3) @(posedge clk);
    #1 chk("irq_n", 16'h0001, {15'h0000, touch_irq_n});
    rd_reg(touch_pkg::ADDR_FIFO, d);
    chk("entry_y", {sample, touch_pkg::KIND_Y, touch_pkg::EV_HOLD_SETUP_BIT}, d);
    // Same position again inside a wide window: nothing new stored
    wr_reg(touch_pkg::ADDR_WINDOW, 16'h0FFF);
    wr_reg(touch_pkg::ADDR_CFG, 16'h0019);
    wait_hi(adc_done, 1'b1);
    wait_hi(adc_done, 1'b1);
    repeat (3) @(posedge clk);
    #1 chk("irq_win", 16'h0001, {15'h0000, touch_irq_n});
    rd_reg(touch_pkg::ADDR_STATUS, d);
    chk("count_win", 16'h0000, {9'h000, d[6:0]});
    @(posedge clk);
    touch_det <= 1'b0;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_level();
    t_edge();
    t_host();
    t_comb();
    t_self();
    summarize();
  end
  initial begin
    #500000;
    bad_count++;
    summarize();
  end
endmodule
